// ### awb_pkg.sv
package awb_pkg;

  // word indices of the bank; byte address is four times the index
  localparam logic [5:0] IDX_NODES_L0_A    = 6'h08;
  localparam logic [5:0] IDX_NODES_L0_B    = 6'h09;
  localparam logic [5:0] IDX_NODES_L0_C    = 6'h0A;
  localparam logic [5:0] IDX_NODES_L0_D    = 6'h0B;
  localparam logic [5:0] IDX_NODES_L1_A    = 6'h0C;
  localparam logic [5:0] IDX_NODES_L1_B    = 6'h0D;
  localparam logic [5:0] IDX_NODES_L1_C    = 6'h0E;
  localparam logic [5:0] IDX_NODES_L1_D    = 6'h0F;
  localparam logic [5:0] IDX_SERVICE_L0    = 6'h10;
  localparam logic [5:0] IDX_SERVICE_L1    = 6'h11;
  localparam logic [5:0] IDX_TRACE_CTRL    = 6'h12;
  localparam logic [5:0] IDX_FS_CTRL       = 6'h13;
  localparam logic [5:0] IDX_FS_CUR_BLOCK  = 6'h14;
  localparam logic [5:0] IDX_FS_BLOCKS_LEFT = 6'h15;
  localparam logic [5:0] IDX_REMOVAL       = 6'h16;
  localparam logic [5:0] IDX_POWER_OFF     = 6'h17;
  localparam logic [5:0] IDX_PRESENCE      = 6'h18;
  localparam logic [5:0] IDX_FAULT_LOW     = 6'h19;
  localparam logic [5:0] IDX_MAX_CYCLE     = 6'h1A;
  localparam logic [5:0] IDX_PRESENT_CYCLE = 6'h1B;

  // trace word bits
  localparam int BIT_TRACE_DONE   = 12;
  localparam int BIT_TRACING      = 13;
  localparam int BIT_TRACE_START  = 14;
  localparam int BIT_SAMPLE_START = 15;

  // file store word bits
  localparam int BIT_FS_ERR_RESET = 0;
  localparam int BIT_FS_XFER      = 1;
  localparam int BIT_FS_DIR_IN    = 2;
  localparam int BIT_FS_ERR_LO    = 3;
  localparam int BIT_FS_LOW_BATT  = 7;
  localparam int BIT_FS_PROT_LO   = 8;
  localparam logic [10:0] FS_PROT_GROUP_BLOCKS = 11'h0FA;
  localparam logic [10:0] FS_LAST_BLOCK        = 11'h7CF;

  // presence and removal word bits
  localparam int BIT_PARAM_L1   = 6;
  localparam int BIT_PARAM_L0   = 7;
  localparam int BIT_MOUNT_LO   = 11;
  localparam int BIT_CPU_DEVICE = 15;
  localparam int BIT_REMOVAL    = 15;

  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] BCD_MAX    = 16'h9999;

  // cycle-time resolution: one tenth of a millisecond
  localparam int CLK_PERIOD_NS = 100;
  localparam int TENTH_MS_NS   = 100000;
  localparam int TENTH_MS_CYCLES = (TENTH_MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {TRC_IDLE, TRC_SAMPLING, TRC_TRACING} awb_trace_type;

endpackage : awb_pkg

// ### awb_aux_status_word_bank.sv
// Register access over APB was left to the implementer.
module awb_aux_status_word_bank
  import awb_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // scan and network link
  input  wire logic        scanEnd,
  input  wire logic        programStart,
  input  wire logic [1:0]  linkOperating,
  input  wire logic [61:0] nodeActiveL0,
  input  wire logic [61:0] nodeActiveL1,
  input  wire logic [1:0]  commCtrlErr,
  input  wire logic [1:0]  eepromErr,
  input  wire logic [1:0]  linkUnitMounted,
  input  wire logic [15:0] serviceTimeL0,
  input  wire logic [15:0] serviceTimeL1,
  // trace engine
  input  wire logic        traceEnd,
  output logic             samplingStartPulse,
  output logic             traceStartPulse,
  // file store unit
  input  wire logic        fsMounted,
  input  wire logic        fsLowBattery,
  input  wire logic        fsXferStart,
  input  wire logic        fsXferDirIn,
  input  wire logic [15:0] fsStartBlock,
  input  wire logic [15:0] fsBlockCount,
  input  wire logic        fsBlockDone,
  input  wire logic        fsErrBlockType,
  input  wire logic        fsErrWriteFail,
  input  wire logic        fsErrChecksum,
  input  wire logic        fsWriteReq,
  input  wire logic [10:0] fsWriteBlock,
  output logic             fsWriteGrant,
  output logic             fsWriteRefused,
  // removal, power, presence, alarm
  input  wire logic        removalActive,
  input  wire logic [11:0] removalFirstWord,
  input  wire logic [2:0]  removalWordCount,
  input  wire logic        powerOn,
  input  wire logic [1:0]  paramMismatch,
  input  wire logic [3:0]  unitMounted,
  input  wire logic        cpuDeviceMounted,
  input  wire logic        alarmRaise,
  input  wire logic [19:0] alarmAddr
);

  logic [15:0] nodeWord_q [8];
  logic [15:0] serviceL0_q, serviceL1_q;
  logic [1:0]  traceCtrl_q;
  logic        tracing_q, traceDone_q;
  awb_trace_type traceState_q;
  logic [1:0]  traceCtrlPrev_q;
  logic        fsErrReset_q, fsXfer_q, fsDirIn_q, fsLowBatt_q;
  logic [3:0]  fsErrSticky_q, fsErrShown_q;
  logic [7:0]  fsProtect_q;
  logic [15:0] fsCurBlock_q, fsBlocksLeft_q;
  logic [15:0] removal_q, powerCount_q;
  logic [15:0] presence_q, faultLow_q;
  logic [15:0] maxCycle_q, presentCycle_q, cycleCount_q;
  logic [9:0]  tickDiv_q;
  logic        tick;

  // bcd add-one on four digits, wrapping 9999 to 0000
  function automatic logic [15:0] bcdInc(input logic [15:0] v);
    logic [15:0] r;
    logic        carry;
    r = v;
    carry = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (carry) begin
        if (r[i*4 +: 4] == 4'h9) begin
          r[i*4 +: 4] = 4'h0;
        end else begin
          r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
          carry = 1'b0;
        end
      end
    end
    return r;
  endfunction : bcdInc

  // bcd subtract-one, stopping at zero
  function automatic logic [15:0] bcdDec(input logic [15:0] v);
    logic [15:0] r;
    logic        borrow;
    r = v;
    borrow = (v != WORD_RESET);
    for (int i = 0; i < 4; i++) begin
      if (borrow) begin
        if (r[i*4 +: 4] == 4'h0) begin
          r[i*4 +: 4] = 4'h9;
        end else begin
          r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
          borrow = 1'b0;
        end
      end
    end
    return r;
  endfunction : bcdDec

  // protect group of a binary block number, 250 blocks each
  function automatic logic [2:0] protGroup(input logic [10:0] blk);
    logic [2:0]  g;
    logic [10:0] rest;
    g = 3'h0;
    rest = blk;
    for (int i = 0; i < 7; i++) begin
      if (rest >= FS_PROT_GROUP_BLOCKS) begin
        rest = rest - FS_PROT_GROUP_BLOCKS;
        g = g + 3'h1;
      end
    end
    return g;
  endfunction : protGroup

  // apb decode; byte lanes 0 and 1 carry the 16-bit word
  logic        apbWrite, apbMapped;
  logic [5:0]  wordIdx;
  logic [15:0] readWord;
  assign wordIdx  = paddr[7:2];
  assign apbMapped = (paddr[1:0] == 2'b00) && (wordIdx >= IDX_NODES_L0_A) && (wordIdx <= IDX_PRESENT_CYCLE);
  assign apbWrite = psel && penable && pwrite && apbMapped;
  assign pready   = 1'b1;

  // one tick per tenth of a millisecond for cycle timing
  always_ff @(posedge sys_clk) begin
    if (srst || scanEnd) begin
      tickDiv_q <= 10'h000;
    end else if (tick) begin
      tickDiv_q <= 10'h000;
    end else begin
      tickDiv_q <= tickDiv_q + 10'h001;
    end
  end
  assign tick = (tickDiv_q == 10'(TENTH_MS_CYCLES - 1));

  // network link words, refreshed at scan end: node words while the link runs, service words while its unit is mounted
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int i = 0; i < 8; i++) begin
        nodeWord_q[i] <= WORD_RESET;
      end
      serviceL0_q <= WORD_RESET;
      serviceL1_q <= WORD_RESET;
    end else if (scanEnd) begin
      if (linkOperating[0]) begin
        nodeWord_q[0] <= nodeActiveL0[15:0];
        nodeWord_q[1] <= nodeActiveL0[31:16];
        nodeWord_q[2] <= nodeActiveL0[47:32];
        nodeWord_q[3] <= {eepromErr[0], commCtrlErr[0], nodeActiveL0[61:48]};
      end
      if (linkOperating[1]) begin
        nodeWord_q[4] <= nodeActiveL1[15:0];
        nodeWord_q[5] <= nodeActiveL1[31:16];
        nodeWord_q[6] <= nodeActiveL1[47:32];
        nodeWord_q[7] <= {eepromErr[1], commCtrlErr[1], nodeActiveL1[61:48]};
      end
      if (linkUnitMounted[0]) begin
        serviceL0_q <= serviceTimeL0;
      end
      if (linkUnitMounted[1]) begin
        serviceL1_q <= serviceTimeL1;
      end
    end
  end

  // trace control bits written by software; the engine acts on their edges
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      traceCtrl_q     <= 2'b00;
      traceCtrlPrev_q <= 2'b00;
    end else begin
      traceCtrlPrev_q <= traceCtrl_q;
      if (apbWrite && wordIdx == IDX_TRACE_CTRL && pstrb[1]) begin
        traceCtrl_q <= {pwdata[BIT_SAMPLE_START], pwdata[BIT_TRACE_START]};
      end
    end
  end

  // rising edges only; a bit left on does not restart anything
  assign samplingStartPulse = traceCtrl_q[1] && !traceCtrlPrev_q[1];
  assign traceStartPulse    = traceCtrl_q[0] && !traceCtrlPrev_q[0] && (traceState_q == TRC_SAMPLING);

  // trace sequence; an end event wins over a restart in the same cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      traceState_q <= TRC_IDLE;
    end else begin
      unique case (traceState_q)
        TRC_IDLE: begin
          if (samplingStartPulse) begin
            traceState_q <= TRC_SAMPLING;
          end
        end
        TRC_SAMPLING: begin
          if (traceStartPulse) begin
            traceState_q <= TRC_TRACING;
          end
        end
        TRC_TRACING: begin
          if (traceEnd) begin
            traceState_q <= TRC_IDLE;
          end
        end
      endcase
    end
  end

  // flags published once per scan; the done bit as read also rises at once on an end via traceEndSeen_q
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tracing_q   <= 1'b0;
      traceDone_q <= 1'b0;
    end else if (scanEnd) begin
      tracing_q <= (traceState_q == TRC_TRACING);
      // an end seen between scans must still latch completion here
      if (traceEndSeen_q || (traceState_q == TRC_TRACING && traceEnd)) begin
        traceDone_q <= 1'b1;
        tracing_q   <= 1'b0;
      end else if (traceState_q != TRC_IDLE) begin
        traceDone_q <= 1'b0;
      end
    end
  end

  // a stray end between scans still leaves the completion visible
  logic traceEndSeen_q;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      traceEndSeen_q <= 1'b0;
    end else if (traceState_q == TRC_TRACING && traceEnd) begin
      traceEndSeen_q <= 1'b1;
    end else if (scanEnd) begin
      traceEndSeen_q <= 1'b0;
    end
  end

  // write protection check, answered in the same cycle as the request
  logic writeProtected;
  assign writeProtected = (fsWriteBlock > FS_LAST_BLOCK) ? 1'b0 : fsProtect_q[protGroup(fsWriteBlock)];
  assign fsWriteRefused = fsWriteReq && writeProtected;
  assign fsWriteGrant   = fsWriteReq && !writeProtected;

  // protect bits and error reset bit; reset bit self-clears after one cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fsProtect_q  <= 8'h00;
      fsErrReset_q <= 1'b0;
    end else begin
      fsErrReset_q <= 1'b0;
      if (apbWrite && wordIdx == IDX_FS_CTRL) begin
        if (pstrb[1]) begin
          fsProtect_q <= pwdata[BIT_FS_PROT_LO +: 8];
        end
        if (pstrb[0]) begin
          fsErrReset_q <= pwdata[BIT_FS_ERR_RESET];
        end
      end
    end
  end

  // sticky errors; a new event beats the reset in the same cycle
  logic [3:0] fsErrEvents;
  assign fsErrEvents = {fsErrChecksum, fsErrWriteFail, fsWriteRefused, fsErrBlockType};
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fsErrSticky_q <= 4'h0;
    end else if (fsErrReset_q) begin
      fsErrSticky_q <= fsErrEvents;
    end else begin
      fsErrSticky_q <= fsErrSticky_q | fsErrEvents;
    end
  end

  // visible error and battery flags; an error reset clears the error flags at once and leaves the battery flag
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fsErrShown_q <= 4'h0;
      fsLowBatt_q  <= 1'b0;
    end else if (fsErrReset_q) begin
      fsErrShown_q <= 4'h0;
    end else if (scanEnd && fsMounted) begin
      fsErrShown_q <= fsErrSticky_q;
      fsLowBatt_q  <= fsLowBattery;
    end
  end

  // transfer state and bcd block counters
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fsXfer_q       <= 1'b0;
      fsDirIn_q      <= 1'b0;
      fsCurBlock_q   <= WORD_RESET;
      fsBlocksLeft_q <= WORD_RESET;
    end else if (fsXferStart) begin
      fsXfer_q       <= (fsBlockCount != WORD_RESET);
      fsDirIn_q      <= fsXferDirIn;
      fsCurBlock_q   <= fsStartBlock;
      fsBlocksLeft_q <= fsBlockCount;
    end else if (fsBlockDone && fsXfer_q) begin
      fsBlocksLeft_q <= bcdDec(fsBlocksLeft_q);
      if (fsBlocksLeft_q == 16'h0001) begin
        fsXfer_q <= 1'b0;
      end else begin
        fsCurBlock_q <= bcdInc(fsCurBlock_q);
      end
    end
  end

  // removal word is rewritten at each scan while a removal runs
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      removal_q <= WORD_RESET;
    end else if (scanEnd) begin
      if (removalActive) begin
        removal_q <= {1'b1, removalWordCount, removalFirstWord};
      end else begin
        removal_q[BIT_REMOVAL] <= 1'b0;
      end
    end
  end

  // power-off count; an increment after a clear yields one
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      powerCount_q <= WORD_RESET;
    end else if (apbWrite && wordIdx == IDX_POWER_OFF && pstrb[1:0] == 2'b11) begin
      powerCount_q <= powerOn ? 16'h0001 : WORD_RESET;
    end else if (powerOn) begin
      powerCount_q <= bcdInc(powerCount_q);
    end
  end

  // presence, mismatch and alarm address, refreshed at scan end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      presence_q <= WORD_RESET;
      faultLow_q <= WORD_RESET;
    end else if (scanEnd) begin
      presence_q[BIT_PARAM_L1]           <= paramMismatch[1];
      presence_q[BIT_PARAM_L0]           <= paramMismatch[0];
      presence_q[BIT_MOUNT_LO +: 4]      <= unitMounted;
      presence_q[BIT_CPU_DEVICE]         <= cpuDeviceMounted;
      if (alarmRaise) begin
        presence_q[3:0] <= alarmAddr[19:16];
        faultLow_q      <= alarmAddr[15:0];
      end
    end
  end

  // cycle timer in bcd tenths, saturating at 999.9 ms
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cycleCount_q   <= WORD_RESET;
      presentCycle_q <= WORD_RESET;
      maxCycle_q     <= WORD_RESET;
    end else begin
      if (scanEnd) begin
        cycleCount_q   <= WORD_RESET;
        presentCycle_q <= cycleCount_q;
        if (programStart || cycleCount_q > maxCycle_q) begin
          maxCycle_q <= cycleCount_q;
        end
      end else begin
        if (tick && cycleCount_q != BCD_MAX) begin
          cycleCount_q <= bcdInc(cycleCount_q);
        end
        if (programStart) begin
          maxCycle_q <= WORD_RESET;
        end
      end
    end
  end

  // read mux; unused bits stay zero, nothing here clears on mode change
  always_comb begin
    readWord = WORD_RESET;
    unique case (wordIdx)
      IDX_NODES_L0_A, IDX_NODES_L0_B, IDX_NODES_L0_C, IDX_NODES_L0_D,
      IDX_NODES_L1_A, IDX_NODES_L1_B, IDX_NODES_L1_C, IDX_NODES_L1_D: begin
        readWord = nodeWord_q[3'(wordIdx - IDX_NODES_L0_A)];
      end
      IDX_SERVICE_L0:     readWord = serviceL0_q;
      IDX_SERVICE_L1:     readWord = serviceL1_q;
      IDX_TRACE_CTRL:     readWord = {traceCtrl_q, tracing_q, traceDone_q | traceEndSeen_q, 12'h000};
      IDX_FS_CTRL:        readWord = {fsProtect_q, fsLowBatt_q, fsErrShown_q, fsDirIn_q, fsXfer_q, fsErrReset_q};
      IDX_FS_CUR_BLOCK:   readWord = fsCurBlock_q;
      IDX_FS_BLOCKS_LEFT: readWord = fsBlocksLeft_q;
      IDX_REMOVAL:        readWord = removal_q;
      IDX_POWER_OFF:      readWord = powerCount_q;
      IDX_PRESENCE:       readWord = presence_q;
      IDX_FAULT_LOW:      readWord = faultLow_q;
      IDX_MAX_CYCLE:      readWord = maxCycle_q;
      IDX_PRESENT_CYCLE:  readWord = presentCycle_q;
      default:            readWord = WORD_RESET;
    endcase
  end

  // registered read data and error; writes to read-only bits are dropped
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= (apbMapped && !pwrite) ? {16'h0000, readWord & 16'hFFFF} : 32'h0000_0000;
      pslverr <= !apbMapped;
    end
  end

endmodule : awb_aux_status_word_bank

// ### awb_monitor.sv
module awb_monitor
  import awb_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        samplingStartPulse,
  input wire logic        traceStartPulse,
  input wire logic        fsWriteReq,
  input wire logic [10:0] fsWriteBlock,
  input wire logic        fsWriteGrant,
  input wire logic        fsWriteRefused
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  // trace word write in the access phase, upper lane enabled
  logic trcWr;
  logic acc;
  logic badAddr;
  assign trcWr   = psel && penable && pwrite && paddr == 8'h48 && pstrb[1];
  assign acc     = psel && penable;
  assign badAddr = paddr[1:0] != 2'h0 || paddr < 8'h20 || paddr > 8'h6C;

  AST_SAMPLE_CAUSE: assert property (samplingStartPulse |-> $past(trcWr && pwdata[15]))
    else $error("sampling pulse without a start bit write");
  AST_SAMPLE_ONCE: assert property (samplingStartPulse |=> !samplingStartPulse)
    else $error("sampling pulse longer than one cycle");
  AST_TRACE_CAUSE: assert property (traceStartPulse |-> $past(trcWr && pwdata[14]))
    else $error("trace pulse without a trace bit write");
  AST_REFUSE_RANGE: assert property (fsWriteRefused |-> fsWriteReq && !fsWriteGrant && fsWriteBlock < 11'h7D0)
    else $error("refusal outside a protected request");
  AST_GRANT_REQ: assert property (fsWriteGrant |-> fsWriteReq && !fsWriteRefused)
    else $error("grant without a request");
  AST_HIGH_BLOCK: assert property (fsWriteReq && fsWriteBlock > 11'h7CF |-> fsWriteGrant)
    else $error("block above the guarded range not granted");
  AST_UNMAPPED: assert property (acc && badAddr |-> pslverr && (pwrite || prdata == 32'h0000_0000))
    else $error("unmapped access not flagged");
  AST_UPPER_ZERO: assert property (acc |-> prdata[31:16] == 16'h0000 && pready)
    else $error("upper read half not zero");

  cover property (samplingStartPulse);
  cover property (traceStartPulse);
  cover property (fsWriteRefused);
endmodule : awb_monitor

bind awb_aux_status_word_bank awb_monitor u_mon (.sys_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .prdata, .pready, .pslverr, .samplingStartPulse, .traceStartPulse, .fsWriteReq, .fsWriteBlock,
  .fsWriteGrant, .fsWriteRefused);

// ### awb_aux_status_word_bank_tb_top.sv
module awb_aux_status_word_bank_tb_top
  import awb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        sys_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, scanEnd = 0, programStart = 0;
  logic        traceEnd = 0, fsMounted = 0, fsLowBattery = 0, fsXferStart = 0, fsXferDirIn = 0;
  logic        fsBlockDone = 0, fsErrBlockType = 0, fsErrWriteFail = 0, fsErrChecksum = 0, fsWriteReq = 0;
  logic        removalActive = 0, powerOn = 0, cpuDeviceMounted = 0, alarmRaise = 0;
  logic [1:0]  linkOperating = '0, commCtrlErr = '0, eepromErr = '0, linkUnitMounted = '0, paramMismatch = '0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0]  pstrb = '0, unitMounted = '0;
  logic [61:0] nodeActiveL0 = '0, nodeActiveL1 = '0;
  logic [15:0] serviceTimeL0 = '0, serviceTimeL1 = '0, fsStartBlock = '0, fsBlockCount = '0;
  logic [10:0] fsWriteBlock = '0;
  logic [11:0] removalFirstWord = '0;
  logic [2:0]  removalWordCount = '0;
  logic [19:0] alarmAddr = '0;
  logic [31:0] prdata;
  logic        pready, pslverr, samplingStartPulse, traceStartPulse, fsWriteGrant, fsWriteRefused;
  int          bad_count = 0, n_checks = 0, cyc = 0, nSamp = 0, nTrc = 0;

  awb_aux_status_word_bank dut (.sys_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .scanEnd, .programStart, .linkOperating, .nodeActiveL0, .nodeActiveL1, .commCtrlErr,
    .eepromErr, .linkUnitMounted, .serviceTimeL0, .serviceTimeL1, .traceEnd, .samplingStartPulse,
    .traceStartPulse, .fsMounted, .fsLowBattery, .fsXferStart, .fsXferDirIn, .fsStartBlock, .fsBlockCount,
    .fsBlockDone, .fsErrBlockType, .fsErrWriteFail, .fsErrChecksum, .fsWriteReq, .fsWriteBlock, .fsWriteGrant,
    .fsWriteRefused, .removalActive, .removalFirstWord, .removalWordCount, .powerOn, .paramMismatch,
    .unitMounted, .cpuDeviceMounted, .alarmRaise, .alarmAddr);

  // 100 ns period
  always #50 sys_clk = ~sys_clk;

  // hang guard plus pulse counters; pulses last one cycle so count at edges
  always @(posedge sys_clk) begin
    cyc++;
    if (samplingStartPulse === 1'b1) nSamp++;
    if (traceStartPulse === 1'b1) nTrc++;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      bad_count++;
      $display("wrong value at %0t: got %h exp %h", $time, g, x);
    end
  endtask : chk

  // one apb transfer; request held until pready seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s,
                     output logic [31:0] r, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    // the wait ends on pready; if it never rises, the bench's cycle ceiling ends it
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 16'h0000, 4'h0, r, e);
    chk(r, x);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, s, r, e);
  endtask : wr

  // refreshes land only on the scan-end pulse
  task automatic scan();
    @(posedge sys_clk);
    scanEnd <= 1'b1;
    @(posedge sys_clk);
    scanEnd <= 1'b0;
  endtask : scan

  task automatic t_nodes();
    logic [61:0] v;
    logic [1:0]  k4;
    @(posedge sys_clk);
    nodeActiveL0 <= 62'h2AAA_5555_F0F0_1234;
    nodeActiveL1 <= 62'h1111_2222_3333_4444;
    commCtrlErr <= 2'h1;
    eepromErr <= 2'h2;
    linkOperating <= 2'h3;
    scan();
    for (int k = 0; k < 8; k++) begin
      v = k < 4 ? nodeActiveL0 : nodeActiveL1;
      k4 = 2'(k);
      rd(8'h20 + 8'(4 * k), k4 == 2'h3 ? {16'h0000, eepromErr[k / 4], commCtrlErr[k / 4], v[61:48]}
                                       : {16'h0000, v[16 * k4 +: 16]});
    end
    $display("test nodes done");
  endtask : t_nodes

  task automatic t_service();
    @(posedge sys_clk);
    serviceTimeL0 <= 16'h9999;
    serviceTimeL1 <= 16'h0123;
    linkUnitMounted <= 2'h3;
    scan();
    rd(8'h40, 32'h0000_9999);
    rd(8'h44, 32'h0000_0123);
    $display("test service done");
  endtask : t_service

  task automatic t_trace();
    wr(8'h48, 16'h8000, 4'h2);
    wr(8'h48, 16'h8000, 4'h2);
    wr(8'h48, 16'hC000, 4'h2);
    rd(8'h48, 32'h0000_C000);
    chk(32'(nSamp), 32'h1);
    chk(32'(nTrc), 32'h1);
    scan();
    rd(8'h48, 32'h0000_E000);
    @(posedge sys_clk);
    traceEnd <= 1'b1;
    @(posedge sys_clk);
    traceEnd <= 1'b0;
    scan();
    rd(8'h48, 32'h0000_D000);
    $display("test trace done");
  endtask : t_trace

  task automatic t_file();
    logic [10:0] blk [3] = '{11'h6D6, 11'h6D5, 11'h7D0};
    logic [1:0]  gr  [3] = '{2'h1, 2'h2, 2'h2};
    @(posedge sys_clk);
    fsMounted <= 1'b1;
    fsLowBattery <= 1'b1;
    wr(8'h4C, 16'h8000, 4'h2);
    // guard on the top group only: its first and last neighbours
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      fsWriteReq <= 1'b1;
      fsWriteBlock <= blk[i];
      #1;
      chk(32'({fsWriteGrant, fsWriteRefused}), 32'(gr[i]));
    end
    @(posedge sys_clk);
    fsWriteReq <= 1'b0;
    fsErrBlockType <= 1'b1;
    fsErrWriteFail <= 1'b1;
    fsErrChecksum <= 1'b1;
    @(posedge sys_clk);
    fsErrBlockType <= 1'b0;
    fsErrWriteFail <= 1'b0;
    fsErrChecksum <= 1'b0;
    scan();
    rd(8'h4C, 32'h0000_80F8);
    wr(8'h4C, 16'h8001, 4'h3);
    scan();
    rd(8'h4C, 32'h0000_8080);
    $display("test file done");
  endtask : t_file

  task automatic t_blocks();
    @(posedge sys_clk);
    fsXferStart <= 1'b1;
    fsXferDirIn <= 1'b1;
    fsStartBlock <= 16'h0099;
    fsBlockCount <= 16'h0002;
    @(posedge sys_clk);
    fsXferStart <= 1'b0;
    scan();
    rd(8'h4C, 32'h0000_8086);
    rd(8'h50, 32'h0000_0099);
    rd(8'h54, 32'h0000_0002);
    @(posedge sys_clk);
    fsBlockDone <= 1'b1;
    @(posedge sys_clk);
    fsBlockDone <= 1'b0;
    rd(8'h50, 32'h0000_0100);
    rd(8'h54, 32'h0000_0001);
    $display("test blocks done");
  endtask : t_blocks

  task automatic t_misc();
    logic [31:0] r;
    logic        e;
    @(posedge sys_clk);
    removalActive <= 1'b1;
    removalFirstWord <= 12'h123;
    removalWordCount <= 3'h5;
    paramMismatch <= 2'h2;
    unitMounted <= 4'h5;
    cpuDeviceMounted <= 1'b1;
    alarmRaise <= 1'b1;
    alarmAddr <= 20'h12345;
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      powerOn <= ~powerOn;
    end
    scan();
    rd(8'h58, 32'h0000_D123);
    rd(8'h5C, 32'h0000_0002);
    rd(8'h60, 32'h0000_A841);
    rd(8'h64, 32'h0000_2345);
    @(posedge sys_clk);
    removalActive <= 1'b0;
    scan();
    rd(8'h58, 32'h0000_5123);
    wr(8'h5C, 16'h0000, 4'h3);
    rd(8'h5C, 32'h0000_0000);
    wr(8'h60, 16'hFFFF, 4'h3);
    rd(8'h60, 32'h0000_A841);
    apb(1'b0, 8'h70, 16'h0000, 4'h0, r, e);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 8'h22, 16'h0000, 4'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    $display("test misc done");
  endtask : t_misc

  // tick is 1000 clocks; gaps end well clear of a tick boundary so rounding cannot matter
  task automatic t_cycle();
    scan();
    @(posedge sys_clk);
    programStart <= 1'b1;
    @(posedge sys_clk);
    programStart <= 1'b0;
    rd(8'h60, 32'h0000_A841);
    repeat (2500) @(posedge sys_clk);
    scan();
    rd(8'h6C, 32'h0000_0002);
    repeat (1200) @(posedge sys_clk);
    scan();
    rd(8'h6C, 32'h0000_0001);
    rd(8'h68, 32'h0000_0002);
    $display("test cycle done");
  endtask : t_cycle

  initial begin
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    t_nodes();
    t_service();
    t_trace();
    t_file();
    t_blocks();
    t_misc();
    t_cycle();
    results();
  end
endmodule : awb_aux_status_word_bank_tb_top
